// ### hdl/event_tc_pkg.sv
// Package for the event force and clear logic: register indices, field layout, resets.
// Assumes a 32-bit AHB-Lite bus and word registers at byte address four times the index.
package event_tc_pkg;

  // Number of event sources and their position in every 16-bit event register.
  localparam int unsigned EVENT_COUNT = 10;
  localparam int unsigned EVENT_LSB   = 6;
  localparam int unsigned EVENT_MSB   = 15;

  // Bit positions of the individual sources.
  localparam int unsigned CURRENT_HIGH_BIT     = 15;
  localparam int unsigned VOLTAGE_HIGH_BIT     = 14;
  localparam int unsigned POWER_HIGH_BIT       = 13;
  localparam int unsigned VOLTAGE_LOW_BIT      = 12;
  localparam int unsigned FREQUENCY_HIGH_BIT   = 11;
  localparam int unsigned FREQUENCY_LOW_BIT    = 10;
  localparam int unsigned TEMPERATURE_HIGH_BIT = 9;
  localparam int unsigned TEMPERATURE_LOW_BIT  = 8;
  localparam int unsigned VOLTAGE_DIP_BIT      = 7;
  localparam int unsigned VOLTAGE_SPIKE_BIT    = 6;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [29:0] FORCE_IDX     = 30'h0000_0090;
  localparam logic [29:0] FLAGS_IDX     = 30'h0000_0091;
  localparam logic [29:0] CLEAR_IDX     = 30'h0000_0092;
  localparam logic [29:0] STD_MASK_IDX  = 30'h0000_0093;
  localparam logic [29:0] CRIT_MASK_IDX = 30'h0000_0094;
  localparam logic [29:0] IRQ_MASK_IDX  = 30'h0000_0095;

  // Reset values of every stored field.
  localparam logic [EVENT_COUNT-1:0] EVENT_RESET = 10'h000;
  localparam logic [31:0]            RDATA_ZERO  = 32'h0000_0000;

  // AHB transfer type that starts a single transfer.
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // Address phase captured for use in the following data phase.
  typedef struct packed {
    logic        sel;
    logic        write;
    logic [29:0] idx;
  } ahb_req_type;

endpackage

// ### hdl/event_test_and_clear_logic.sv
// Event force and clear logic with its AHB-Lite register slave and notification pins.
// Assumes one slave per bus with zero wait states; detection pulses are synchronous to hclk.
// How the pieces fit together
// Each of the ten event sources keeps two sticky bits of state. The detected bit is set by a
// pulse or level on detect_in and stays set after the condition passes. The forced bit is set
// by software through the force register. The flag that software reads is the union of both,
// so either cause keeps the event visible and the notification pins see one picture.
//
// Writing the force register replaces the whole forced set. A zero therefore withdraws a
// forced event, but it can never touch a detected one, because the detected set lives in a
// separate register. This split is the reason for keeping two vectors instead of one.
//
// The clear register does not hold its value. A written one is kept for exactly one cycle,
// during which it can be read back, and at the next edge it takes down both the detected and
// the forced bit of that source and returns to zero by itself. Software that polls the
// clear register straight after a write may therefore still see its own bits for one cycle.
//
// The flag register doubles as interrupt status: a one written to a flag bit clears both
// causes at once, in the same way as the clear register but without the one-cycle delay.
//
// A detection that lands in the same cycle as a clear wins, so a real fault that comes back
// while software is tidying up is never lost. The price is that software must read the flags
// again after clearing to be sure that the condition has really gone away.
//
// The three output pins are registered. They follow the flags one cycle later, which keeps
// them free of glitches from the decode logic at the cost of one cycle of latency.
//
// Limitations: the bus slave answers every transfer at once and never stalls. Unaligned
// addresses and unmapped indices read as zero and ignore writes. hsize is not checked, so a
// narrow write updates the whole register from the full data word.
//
// Our own choice: the AHB-Lite register port.
module event_test_and_clear_logic (
  input  wire logic        hclk,          // System clock, 200 MHz.
  input  wire logic        hresetn,       // Asynchronous reset, active low.
  input  wire logic        hsel,          // Slave select.
  input  wire logic [31:0] haddr,         // Byte address.
  input  wire logic [1:0]  htrans,        // Transfer type.
  input  wire logic        hwrite,        // Write when high.
  input  wire logic [2:0]  hsize,         // Only whole words are used.
  input  wire logic [31:0] hwdata,        // Write data.
  input  wire logic        hready,        // Bus ready from the interconnect.
  input  wire logic [9:0]  detect_in,     // Limit breach pulses, bit 9 is current high.
  output logic      [31:0] hrdata,        // Read data.
  output logic             hreadyout,     // Always ready.
  output logic             hresp,         // Always OKAY.
  output logic             standard_pin,  // Standard notification output.
  output logic             critical_pin,  // Critical notification output.
  output logic             irq            // Level interrupt.
);

  localparam int unsigned N  = event_tc_pkg::EVENT_COUNT;
  localparam int unsigned LO = event_tc_pkg::EVENT_LSB;
  localparam int unsigned HI = event_tc_pkg::EVENT_MSB;

  // Captured address phase and the stored fields.
  event_tc_pkg::ahb_req_type req_q, req_d;  // Address phase held for the data phase.
  logic [N-1:0] true_q,  true_d;            // Events raised by real detection.
  logic [N-1:0] force_q, force_d;           // Events forced by software.
  logic [N-1:0] clr_q,   clr_d;             // Pending clear bits, self clearing.
  logic [N-1:0] std_mask_q,  std_mask_d;    // Events routed to the standard pin.
  logic [N-1:0] crit_mask_q, crit_mask_d;   // Events routed to the critical pin.
  logic [N-1:0] irq_mask_q,  irq_mask_d;    // Events routed to the interrupt.
  logic         std_q, crit_q, irq_q;       // Registered pin levels.

  // Decode of the data phase; every register is one aligned word.
  // Writes act in the data phase, one cycle after the address phase that named them, so the
  // strobes below are built from the captured request and not from the live bus.
  wire          addr_phase = hsel && hready && (htrans == event_tc_pkg::HTRANS_NONSEQ);
  wire          wr_any     = req_q.sel && req_q.write;
  wire          rd_active  = req_q.sel && !req_q.write;
  wire          wr_force   = wr_any && (req_q.idx == event_tc_pkg::FORCE_IDX);
  wire          wr_flags   = wr_any && (req_q.idx == event_tc_pkg::FLAGS_IDX);
  wire          wr_clear   = wr_any && (req_q.idx == event_tc_pkg::CLEAR_IDX);
  wire          wr_std     = wr_any && (req_q.idx == event_tc_pkg::STD_MASK_IDX);
  wire          wr_crit    = wr_any && (req_q.idx == event_tc_pkg::CRIT_MASK_IDX);
  wire          wr_irq     = wr_any && (req_q.idx == event_tc_pkg::IRQ_MASK_IDX);
  wire [N-1:0]  hw_bits    = hwdata[HI:LO];
  wire [N-1:0]  w1c_bits   = wr_flags ? hw_bits : event_tc_pkg::EVENT_RESET;

  // The visible flag is the union of detected and forced events.
  wire [N-1:0]  flag_vec   = true_q | force_q;

  // Address phase capture; the upper address bits form the word index.
  assign req_d.sel   = addr_phase && (haddr[1:0] == 2'h0);
  assign req_d.write = hwrite;
  assign req_d.idx   = haddr[31:2];

  // A detection in the same cycle as a clear survives, so no event is lost.
  assign true_d = (true_q & ~clr_q & ~w1c_bits) | detect_in;

  // A force write replaces the forced set; a zero only withdraws forced events.
  // Clears take the force bit down as well so a cleared event does not reappear.
  assign force_d = (wr_force ? hw_bits : force_q) & ~clr_q & ~w1c_bits;

  // Clear bits live for one cycle: they act at the next edge and vanish with it.
  assign clr_d = wr_clear ? hw_bits : event_tc_pkg::EVENT_RESET;

  // Mask registers keep their value unless written.
  assign std_mask_d  = wr_std  ? hw_bits : std_mask_q;
  assign crit_mask_d = wr_crit ? hw_bits : crit_mask_q;
  assign irq_mask_d  = wr_irq  ? hw_bits : irq_mask_q;

  // Read mux; the low six bits and bits above fifteen always read as zero.
  // Only stored state reaches the mux, so read data never depends on the live bus inputs.
  wire [N-1:0] rd_sel =
      (req_q.idx == event_tc_pkg::FORCE_IDX)     ? force_q     :
      (req_q.idx == event_tc_pkg::FLAGS_IDX)     ? flag_vec    :
      (req_q.idx == event_tc_pkg::CLEAR_IDX)     ? clr_q       :
      (req_q.idx == event_tc_pkg::STD_MASK_IDX)  ? std_mask_q  :
      (req_q.idx == event_tc_pkg::CRIT_MASK_IDX) ? crit_mask_q :
      (req_q.idx == event_tc_pkg::IRQ_MASK_IDX)  ? irq_mask_q  :
      event_tc_pkg::EVENT_RESET;

  // Unmapped addresses read zero; hrdata is a mux of flip-flops only.
  assign hrdata    = rd_active ? {16'h0000, rd_sel, 6'h00} : event_tc_pkg::RDATA_ZERO;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Pins follow the masks one cycle after the flags move.
  assign standard_pin = std_q;
  assign critical_pin = crit_q;
  assign irq          = irq_q;

  // Bus capture register.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_q <= '0;
    end else begin
      req_q <= req_d;
    end
  end

  // Event state; all fields reset to zero.
  // The three vectors share one process because they move together on every clear.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      true_q  <= event_tc_pkg::EVENT_RESET;
      force_q <= event_tc_pkg::EVENT_RESET;
      clr_q   <= event_tc_pkg::EVENT_RESET;
    end else begin
      true_q  <= true_d;
      force_q <= force_d;
      clr_q   <= clr_d;
    end
  end

  // Mask registers.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      std_mask_q  <= event_tc_pkg::EVENT_RESET;
      crit_mask_q <= event_tc_pkg::EVENT_RESET;
      irq_mask_q  <= event_tc_pkg::EVENT_RESET;
    end else begin
      std_mask_q  <= std_mask_d;
      crit_mask_q <= crit_mask_d;
      irq_mask_q  <= irq_mask_d;
    end
  end

  // Notification pins go high while any routed event is active.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      std_q  <= 1'b0;
      crit_q <= 1'b0;
      irq_q  <= 1'b0;
    end else begin
      std_q  <= |(flag_vec & std_mask_q);
      crit_q <= |(flag_vec & crit_mask_q);
      irq_q  <= |(flag_vec & irq_mask_q);
    end
  end

  // Checks on the behaviour above.
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  force_raises_a: assert property (wr_force |=> ((flag_vec & $past(hw_bits)) == $past(hw_bits)) || $past(clr_q != 0) || $past(wr_flags))
    else $error("Forced event did not raise its flag.");

  force_zero_a: assert property ((wr_force && clr_q == 0) |=> force_q == $past(hw_bits))
    else $error("Force register did not take written value.");

  force_keeps_true_a: assert property ((wr_force && clr_q == 0) |=> (true_q & $past(true_q)) == $past(true_q))
    else $error("Force write dropped a detected event.");

  low_bits_zero_a: assert property (rd_active |-> hrdata[5:0] == 6'h00)
    else $error("Unimplemented bits read nonzero.");

  clear_removes_a: assert property ((clr_q != 0 && (detect_in & clr_q) == 0) |=> (flag_vec & $past(clr_q)) == 0)
    else $error("Clear did not remove the event.");

  clear_force_a: assert property ((clr_q != 0) |=> (force_q & $past(clr_q)) == 0)
    else $error("Clear left the force bit set.");

  clear_self_a: assert property ((clr_q != 0 && !wr_clear) |=> clr_q == 0)
    else $error("Clear bits did not return to zero.");

  latch_hold_a: assert property ((clr_q == 0 && !wr_flags) |=> (true_q & $past(true_q)) == $past(true_q))
    else $error("Latched event dropped without clear.");

  pin_follow_a: assert property ((|(flag_vec & std_mask_q)) |=> standard_pin)
    else $error("Standard pin not high for masked event.");

  crit_follow_a: assert property ((|(flag_vec & crit_mask_q)) |=> critical_pin)
    else $error("Critical pin not high for masked event.");

  irq_follow_a: assert property ((|(flag_vec & irq_mask_q)) |=> irq)
    else $error("Interrupt not high for masked event.");

  std_drop_a: assert property (!(|(flag_vec & std_mask_q)) |=> !standard_pin)
    else $error("Standard pin high without a masked event.");

  crit_drop_a: assert property (!(|(flag_vec & crit_mask_q)) |=> !critical_pin)
    else $error("Critical pin high without a masked event.");

  irq_drop_a: assert property (!(|(flag_vec & irq_mask_q)) |=> !irq)
    else $error("Interrupt high without a masked event.");

  high_bits_zero_a: assert property (hrdata[31:16] == 16'h0000)
    else $error("Upper read bits nonzero.");

  idle_rdata_a: assert property (!rd_active |-> hrdata == event_tc_pkg::RDATA_ZERO)
    else $error("Read data driven outside a read.");

  force_flag_a: assert property ((wr_force && clr_q == 0) |=> (flag_vec & $past(true_q)) == $past(true_q))
    else $error("Force write hid a detected flag.");

  flag_clear_a: assert property ((wr_flags && (detect_in & hw_bits) == 0) |=> (flag_vec & $past(hw_bits)) == 0)
    else $error("Flag write did not clear the event.");

  always_ready_a: assert property (hreadyout && !hresp)
    else $error("Slave stalled or reported an error.");

  detect_wins_a: assert property (((detect_in & clr_q) != 0) |=> (true_q & $past(detect_in & clr_q)) == $past(detect_in & clr_q))
    else $error("Clear beat a simultaneous detection.");

  force_cover_c: cover property (wr_force && hw_bits != 0 ##1 flag_vec != 0);
  clear_cover_c: cover property (clr_q != 0 && force_q != 0);
  race_cover_c:  cover property ((detect_in & clr_q) != 0);
  pin_cover_c:   cover property (critical_pin && standard_pin);
  w1c_cover_c:   cover property (wr_flags && hw_bits != 0);

endmodule

// ### bench/test_event_test_and_clear_logic.sv
// Self-checking bench for the event force and clear logic, driven over AHB-Lite.
// Assumes the event_tc_pkg package is compiled first and the block is the only bus slave.
module test_event_test_and_clear_logic;
  timeunit 1ns;
  timeprecision 1ps;
  // Byte addresses are four times the register index.
  localparam logic [31:0] A_FORCE = {event_tc_pkg::FORCE_IDX, 2'h0};
  localparam logic [31:0] A_FLAGS = {event_tc_pkg::FLAGS_IDX, 2'h0};
  localparam logic [31:0] A_CLEAR = {event_tc_pkg::CLEAR_IDX, 2'h0};
  localparam logic [31:0] A_STD   = {event_tc_pkg::STD_MASK_IDX, 2'h0};
  localparam logic [31:0] A_CRIT  = {event_tc_pkg::CRIT_MASK_IDX, 2'h0};
  localparam logic [31:0] A_IRQ   = {event_tc_pkg::IRQ_MASK_IDX, 2'h0};
  logic        hclk = 1'b0;  // Bus clock, 5 ns period.
  logic        hresetn;      // Active-low reset.
  logic        hsel;         // Slave select.
  logic [31:0] haddr;        // Byte address.
  logic [1:0]  htrans;       // Transfer type.
  logic        hwrite;       // Write strobe.
  logic [2:0]  hsize;        // Always a whole word.
  logic [31:0] hwdata;       // Write data.
  logic [9:0]  detect_in;    // Detection inputs.
  logic [31:0] hrdata;       // Read data.
  logic        hreadyout;    // Slave ready, fed back as hready.
  logic        hresp;        // Response, checked once after reset.
  logic        standard_pin; // Standard notification.
  logic        critical_pin; // Critical notification.
  logic        irq;          // Level interrupt.
  logic [31:0] rd;           // Last read word.
  int          num_errors = 0;
  int          cmp_count = 0;
  // The clock toggles every half period.
  always #2.5 hclk = ~hclk;
  event_test_and_clear_logic event_test_and_clear_logic_inst (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .hsel         (hsel),
    .haddr        (haddr),
    .htrans       (htrans),
    .hwrite       (hwrite),
    .hsize        (hsize),
    .hwdata       (hwdata),
    .hready       (hreadyout),
    .detect_in    (detect_in),
    .hrdata       (hrdata),
    .hreadyout    (hreadyout),
    .hresp        (hresp),
    .standard_pin (standard_pin),
    .critical_pin (critical_pin),
    .irq          (irq)
  );
  // One single transfer; entered just after a rising edge, returns at the data phase's end.
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= event_tc_pkg::HTRANS_NONSEQ;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    // Read data is taken at the edge that ends the data phase, before the slave moves on.
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask
  // Compares one word and counts the result.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Pins are registered one cycle behind the flags, so look after the next edge.
  task automatic pins(input logic [2:0] e);
    repeat (2) @(negedge hclk);
    chk({29'h0, standard_pin, critical_pin, irq}, {29'h0, e});
    @(posedge hclk);
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // The whole sequence needs under a hundred cycles, so this limit only catches a hang.
  initial begin
    #50us;
    num_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    summarize();
  end
  initial begin
    {hresetn, hsel, haddr, htrans, hwrite, hwdata, detect_in} = '0;
    hsize = 3'h2;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, A_FORCE, 32'h0, rd); chk(rd, 32'h0);
    bus(1'b0, A_CLEAR, 32'h0, rd); chk(rd, 32'h0);
    chk({30'h0, hreadyout, hresp}, 32'h2);
    $display("test reset values done");
    bus(1'b1, A_STD, 32'h0000_ffc0, rd);
    bus(1'b1, A_CRIT, 32'h0000_8000, rd);
    bus(1'b1, A_IRQ, 32'h0000_0040, rd);
    bus(1'b1, A_FORCE, 32'hffff_ffff, rd);
    pins(3'b111);
    bus(1'b0, A_FORCE, 32'h0, rd); chk(rd, 32'h0000_ffc0);
    bus(1'b0, A_STD, 32'h0, rd); chk(rd, 32'h0000_ffc0);
    bus(1'b0, A_FLAGS, 32'h0, rd); chk(rd, 32'h0000_ffc0);
    // Dropping only the top source must release the critical pin alone.
    bus(1'b1, A_FORCE, 32'h0000_7fc0, rd);
    pins(3'b101);
    bus(1'b1, A_FORCE, 32'h0, rd);
    bus(1'b0, A_FLAGS, 32'h0, rd); chk(rd, 32'h0);
    pins(3'b000);
    $display("test force done");
    detect_in <= 10'h020;
    @(posedge hclk);
    detect_in <= 10'h000;
    bus(1'b1, A_FORCE, 32'h0, rd);
    bus(1'b0, A_FLAGS, 32'h0, rd); chk(rd, 32'h0000_0800);
    bus(1'b1, A_CLEAR, 32'h0000_0800, rd);
    bus(1'b0, A_CLEAR, 32'h0, rd); chk(rd, 32'h0);
    bus(1'b0, A_FLAGS, 32'h0, rd); chk(rd, 32'h0);
    bus(1'b1, A_FORCE, 32'h0000_0040, rd);
    bus(1'b1, A_CLEAR, 32'h0000_0040, rd);
    bus(1'b0, A_FORCE, 32'h0, rd); chk(rd, 32'h0);
    bus(1'b0, A_FLAGS, 32'h0, rd); chk(rd, 32'h0);
    detect_in <= 10'h002;
    @(posedge hclk);
    detect_in <= 10'h000;
    bus(1'b1, A_FLAGS, 32'h0000_0080, rd);
    bus(1'b0, A_FLAGS, 32'h0, rd); chk(rd, 32'h0);
    $display("test clear done");
    // A detection held through the clear must keep the event latched.
    detect_in <= 10'h001;
    bus(1'b1, A_CLEAR, 32'h0000_0040, rd);
    bus(1'b0, A_FLAGS, 32'h0, rd); chk(rd, 32'h0000_0040);
    detect_in <= 10'h000;
    bus(1'b1, A_CLEAR, 32'h0000_0040, rd);
    bus(1'b0, A_FLAGS, 32'h0, rd); chk(rd, 32'h0);
    bus(1'b1, 32'h0000_0300, 32'hffff_ffff, rd);
    bus(1'b0, 32'h0000_0300, 32'h0, rd); chk(rd, 32'h0);
    bus(1'b0, A_FORCE, 32'h0, rd); chk(rd, 32'h0);
    $display("test detection and unmapped done");
    summarize();
  end
endmodule
